// *** logic/rbfcs_map.vh ***
// register offsets, field positions, reset values and state codes of the receive framing block
`ifndef RBFCS_MAP_VH
`define RBFCS_MAP_VH

// ****************************************
// register offsets
// ****************************************
`define RBFCS_OFS_STATUS     8'h0B
`define RBFCS_OFS_BIT_CTRL   8'h0C
`define RBFCS_OFS_COLL_POS   8'h0D

// ****************************************
// field positions
// ****************************************
`define RBFCS_CIPHER_BIT     5
`define RBFCS_KEEP_BIT       7
`define RBFCS_ALIGN_HI       6
`define RBFCS_ALIGN_LO       4
`define RBFCS_COLL_ERR_BIT   3
`define RBFCS_LAST_HI        2
`define RBFCS_LAST_LO        0
`define RBFCS_CVALID_BIT     7

// ****************************************
// reset values
// ****************************************
`define RBFCS_RST_BIT_CTRL   8'h00
`define RBFCS_RST_COLL_POS   7'h00
`define RBFCS_RST_RDATA      8'h00

// ****************************************
// transceiver state codes and limits
// ****************************************
`define RBFCS_ST_IDLE        3'h0
`define RBFCS_ST_TX_WAIT     3'h1
`define RBFCS_ST_TX          3'h3
`define RBFCS_ST_RX_WAIT     3'h5
`define RBFCS_ST_WAIT_DATA   3'h6
`define RBFCS_ST_RX          3'h7
`define RBFCS_COLL_MAX_IDX   8'h3F

`endif

// *** logic/rbfcs_bit_packer.v ***
// packs a serial receive bit stream into bytes starting at a chosen bit position
`timescale 1ns/1ps
module rbfcs_bit_packer (
   // clock and reset
   input  wire       ref_clk_i,
   input  wire       reset_n_i,
   // control
   input  wire       start_i,     // start of reception, loads position
   input  wire [2:0] align_i,     // position of first stored bit
   input  wire       flush_i,     // end of frame, push partial byte
   // bit stream
   input  wire       bit_valid_i,
   input  wire       bit_i,
   // byte output
   output reg        byte_valid_o,
   output reg  [7:0] byte_o,
   output reg  [2:0] fill_o       // next free position in current byte
);

   reg [7:0] acc_ff;               // byte under construction
   reg [7:0] nxt_acc;

   // ****************************************
   // next accumulator value
   // ****************************************
   always @* begin
      nxt_acc = acc_ff;
      nxt_acc[fill_o] = bit_i;
   end

   // ****************************************
   // fill position and byte hand-off
   // ****************************************
   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         acc_ff       <= 8'h00;
         byte_o       <= 8'h00;
         byte_valid_o <= 1'b0;
         fill_o       <= 3'h0;
      end else begin
         byte_valid_o <= 1'b0;
         if (start_i) begin
            // positions below the start stay zero
            acc_ff <= 8'h00;
            fill_o <= align_i;
         end else if (bit_valid_i) begin
            if (fill_o == 3'h7) begin
               // top position filled, the next bit goes to bit 0 of a new byte
               byte_o       <= nxt_acc;
               byte_valid_o <= 1'b1;
               acc_ff       <= 8'h00;
               fill_o       <= 3'h0;
            end else begin
               acc_ff <= nxt_acc;
               fill_o <= fill_o + 3'h1;
            end
         end else if (flush_i && (fill_o != 3'h0)) begin
            // partial final byte
            byte_o       <= acc_ff;
            byte_valid_o <= 1'b1;
            acc_ff       <= 8'h00;
         end
      end
   end

endmodule

// *** logic/rbfcs_core.v ***
// receive status, bit framing and collision reporting registers with transceiver state machine
`timescale 1ns/1ps
`include "rbfcs_map.vh"
module rbfcs_core (
   // clock and reset
   input  wire       ref_clk_i,
   input  wire       reset_n_i,
   // register port
   input  wire [7:0] reg_addr_i,
   input  wire       reg_wr_i,
   input  wire [7:0] reg_wdata_i,
   input  wire       reg_rd_i,
   output reg  [7:0] reg_rdata_o,
   // command events
   input  wire       cmd_start_i,      // transceive command started
   input  wire       cmd_stop_i,       // command aborted or ended
   input  wire       auth_done_i,      // authentication command succeeded
   input  wire       tx_go_i,          // transmission begins
   input  wire       tx_done_i,        // last bit sent
   input  wire       rx_enable_i,      // receiver armed
   input  wire       rx_sof_i,         // start of frame seen
   input  wire       rx_end_i,         // end of frame seen
   // receive bit stream
   input  wire       rx_bit_valid_i,
   input  wire       rx_bit_i,
   input  wire       rx_bit_coll_i,    // this bit collided
   input  wire       rx_parity_err_i,
   input  wire       rx_crc_err_i,
   // receive data out
   output wire       rx_byte_valid_o,
   output wire [7:0] rx_byte_o,
   // status out
   output reg  [2:0] transceiver_state_o,
   output reg        card_cipher_active_o,
   output reg        integrity_error_flag_o,
   output reg        collision_detected_o,
   output reg        bit_oriented_o
);

   // ****************************************
   // declarations
   // ****************************************
   reg  [7:0] bit_ctrl_ff;             // keep, align, coll-as-error, last bits
   reg  [6:0] collision_index_ff;      // first collided position
   reg        collision_index_valid_ff;
   reg  [7:0] bit_idx_ff;              // data bit position incl. alignment
   reg  [2:0] nxt_state;
   reg        nxt_int_err;
   wire [2:0] fill_pos;                // packer's next free position
   wire       wr_status;
   wire       wr_bit_ctrl;
   wire       rx_start;                // start of reception
   wire       bit_stored;              // value handed to the packer
   wire       first_coll;
   wire [2:0] first_bit_position;
   wire       keep_bits_past_collision;
   wire       collision_as_error;

   assign wr_status   = reg_wr_i && (reg_addr_i == `RBFCS_OFS_STATUS);
   assign wr_bit_ctrl = reg_wr_i && (reg_addr_i == `RBFCS_OFS_BIT_CTRL);
   assign first_bit_position       = bit_ctrl_ff[`RBFCS_ALIGN_HI:`RBFCS_ALIGN_LO];
   assign keep_bits_past_collision = bit_ctrl_ff[`RBFCS_KEEP_BIT];
   assign collision_as_error       = bit_ctrl_ff[`RBFCS_COLL_ERR_BIT];

   // reception begins when the receiver waits for data
   assign rx_start = (nxt_state == `RBFCS_ST_WAIT_DATA) && (transceiver_state_o != `RBFCS_ST_WAIT_DATA);

   // only the first collision of a frame is recorded
   assign first_coll = rx_bit_valid_i && rx_bit_coll_i && !collision_detected_o;

   // bits after the first collision forced low unless kept
   assign bit_stored = (collision_detected_o && !keep_bits_past_collision) ? 1'b0 : rx_bit_i;

   // ****************************************
   // transceiver state machine
   // ****************************************
   // 100b has no state assigned, so it can never be reported
   always @* begin
      nxt_state = transceiver_state_o;
      if (cmd_stop_i) begin
         nxt_state = `RBFCS_ST_IDLE;
      end else begin
         case (transceiver_state_o)
            `RBFCS_ST_IDLE: begin
               if (cmd_start_i) nxt_state = `RBFCS_ST_TX_WAIT;
            end
            `RBFCS_ST_TX_WAIT: begin
               if (tx_go_i) nxt_state = `RBFCS_ST_TX;
            end
            `RBFCS_ST_TX: begin
               if (tx_done_i) nxt_state = `RBFCS_ST_RX_WAIT;
            end
            `RBFCS_ST_RX_WAIT: begin
               if (rx_enable_i) nxt_state = `RBFCS_ST_WAIT_DATA;
            end
            `RBFCS_ST_WAIT_DATA: begin
               if (rx_sof_i) nxt_state = `RBFCS_ST_RX;
            end
            `RBFCS_ST_RX: begin
               if (rx_end_i) nxt_state = `RBFCS_ST_IDLE;
            end
            default: begin
               // unused code falls back to idle
               nxt_state = `RBFCS_ST_IDLE;
            end
         endcase
      end
   end

   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         transceiver_state_o <= `RBFCS_ST_IDLE;
      end else begin
         transceiver_state_o <= nxt_state;
      end
   end

   // ****************************************
   // cipher flag
   // ****************************************
   // host may only clear; set by authentication wins over a clear
   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         card_cipher_active_o <= 1'b0;
      end else if (auth_done_i) begin
         card_cipher_active_o <= 1'b1;
      end else if (wr_status && !reg_wdata_i[`RBFCS_CIPHER_BIT]) begin
         card_cipher_active_o <= 1'b0;
      end
   end

   // ****************************************
   // bit control register
   // ****************************************
   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bit_ctrl_ff <= `RBFCS_RST_BIT_CTRL;
      end else begin
         if (wr_bit_ctrl) begin
            bit_ctrl_ff <= reg_wdata_i;
         end
         // decoder updates last bits after any host write in the same cycle
         if (rx_start) begin
            bit_ctrl_ff[`RBFCS_LAST_HI:`RBFCS_LAST_LO] <= 3'h0;
         end else if ((transceiver_state_o == `RBFCS_ST_RX) && rx_end_i) begin
            // filled position count of the final byte; zero means a full byte
            bit_ctrl_ff[`RBFCS_LAST_HI:`RBFCS_LAST_LO] <= fill_pos;
         end
      end
   end

   // ****************************************
   // bit-oriented mode indication
   // ****************************************
   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bit_oriented_o <= 1'b0;
      end else begin
         bit_oriented_o <= (first_bit_position != 3'h0);
      end
   end

   // ****************************************
   // collision position tracking
   // ****************************************
   // counter starts at the alignment so the index includes it
   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bit_idx_ff               <= 8'h00;
         collision_index_ff       <= `RBFCS_RST_COLL_POS;
         collision_index_valid_ff <= 1'b0;
         collision_detected_o     <= 1'b0;
      end else if (rx_start) begin
         bit_idx_ff               <= {5'h00, first_bit_position};
         collision_index_ff       <= `RBFCS_RST_COLL_POS;
         collision_index_valid_ff <= 1'b0;
         collision_detected_o     <= 1'b0;
      end else if (rx_bit_valid_i) begin
         // saturate so the index never wraps back into range
         if (bit_idx_ff != 8'hFF) begin
            bit_idx_ff <= bit_idx_ff + 8'h01;
         end
         if (first_coll) begin
            collision_detected_o <= 1'b1;
            if (bit_idx_ff <= `RBFCS_COLL_MAX_IDX) begin
               // counter holds the alignment plus the data bits received, so the index includes the alignment
               collision_index_ff       <= bit_idx_ff[6:0];
               collision_index_valid_ff <= 1'b1;
            end
         end
      end
   end

   // ****************************************
   // integrity error flag
   // ****************************************
   // errors are only flagged; reception carries on regardless
   always @* begin
      nxt_int_err = integrity_error_flag_o;
      if (rx_start) begin
         nxt_int_err = 1'b0;
      end
      // set beats the clear at start of reception
      if (rx_parity_err_i || rx_crc_err_i) begin
         nxt_int_err = 1'b1;
      end
      if (first_coll && collision_as_error) begin
         nxt_int_err = 1'b1;
      end
   end

   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         integrity_error_flag_o <= 1'b0;
      end else begin
         integrity_error_flag_o <= nxt_int_err;
      end
   end

   // ****************************************
   // byte assembly
   // ****************************************
   // packer places first bit at the alignment; wraps at bit 7
   rbfcs_bit_packer u_packer (
      .ref_clk_i    (ref_clk_i),
      .reset_n_i    (reset_n_i),
      .start_i      (rx_start),
      .align_i      (first_bit_position),
      .flush_i      ((transceiver_state_o == `RBFCS_ST_RX) && rx_end_i),
      .bit_valid_i  (rx_bit_valid_i),
      .bit_i        (bit_stored),
      .byte_valid_o (rx_byte_valid_o),
      .byte_o       (rx_byte_o),
      .fill_o       (fill_pos)
   );

   // ****************************************
   // register read
   // ****************************************
   // read data is registered; unmapped offsets read zero
   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         reg_rdata_o <= `RBFCS_RST_RDATA;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            `RBFCS_OFS_STATUS: begin
               // reserved bits 7, 6, 4, 3 read zero
               reg_rdata_o <= {2'h0, card_cipher_active_o, 2'h0, transceiver_state_o};
            end
            `RBFCS_OFS_BIT_CTRL: begin
               reg_rdata_o <= bit_ctrl_ff;
            end
            `RBFCS_OFS_COLL_POS: begin
               // host must check the valid bit before using the index
               reg_rdata_o <= {collision_index_valid_ff, collision_index_ff};
            end
            default: begin
               reg_rdata_o <= 8'h00;
            end
         endcase
      end
   end

endmodule

// *** bench/rbfcs_monitor.sv ***
// concurrent checks on the receive framing block ports
`timescale 1ns/1ps
module rbfcs_monitor (
   // clock, reset and register port
   input wire       ref_clk_i,
   input wire       reset_n_i,
   input wire [7:0] reg_addr_i,
   input wire       reg_wr_i,
   input wire [7:0] reg_wdata_i,
   input wire       reg_rd_i,
   input wire [7:0] reg_rdata_o,
   // command and receive events
   input wire       cmd_start_i,
   input wire       cmd_stop_i,
   input wire       auth_done_i,
   input wire       tx_done_i,
   input wire       rx_enable_i,
   input wire       rx_end_i,
   input wire       rx_parity_err_i,
   input wire       rx_crc_err_i,
   // status outputs
   input wire [2:0] transceiver_state_o,
   input wire       card_cipher_active_o,
   input wire       integrity_error_flag_o,
   input wire       collision_detected_o,
   input wire       bit_oriented_o
);
   wire [2:0] st = transceiver_state_o; // short alias
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   // ****************************************
   // state walk and status bits
   // ****************************************
   property p_no_code4; st != 3'h4; endproperty
   a_no_code4: assert property (p_no_code4) else $error("unused state code");
   property p_start; st == 3'h0 && cmd_start_i && !cmd_stop_i |=> st == 3'h1; endproperty
   a_start: assert property (p_start) else $error("start not taken");
   property p_tx_end; st == 3'h3 && tx_done_i && !cmd_stop_i |=> st == 3'h5; endproperty
   a_tx_end: assert property (p_tx_end) else $error("no receive wait");
   property p_stop; cmd_stop_i |=> st == 3'h0; endproperty
   a_stop: assert property (p_stop) else $error("stop not idle");
   // arming the receiver clears the frame status
   // an error strobe in the arming cycle wins over the clear, so it is left out here
   sequence s_arm; st == 3'h5 && rx_enable_i && !cmd_stop_i && !rx_parity_err_i && !rx_crc_err_i; endsequence
   sequence s_clean; st == 3'h6 && !collision_detected_o && !integrity_error_flag_o; endsequence
   property p_arm; s_arm |=> s_clean; endproperty
   a_arm: assert property (p_arm) else $error("stale frame status");
   property p_auth; auth_done_i |=> card_cipher_active_o; endproperty
   a_auth: assert property (p_auth) else $error("cipher not set");
   property p_cipher_src; $rose(card_cipher_active_o) |-> $past(auth_done_i); endproperty
   a_cipher_src: assert property (p_cipher_src) else $error("cipher set alone");
   property p_mode;
      reg_wr_i && reg_addr_i == 8'h0C |=> ##1 bit_oriented_o == (|$past(reg_wdata_i[6:4], 2));
   endproperty
   a_mode: assert property (p_mode) else $error("wrong bit mode");
   property p_integ;
      st == 3'h7 && rx_parity_err_i && !rx_end_i && !cmd_stop_i |=> integrity_error_flag_o && st == 3'h7;
   endproperty
   a_integ: assert property (p_integ) else $error("parity not flagged");
   property p_rd_status;
      reg_rd_i && reg_addr_i == 8'h0B |=> reg_rdata_o == {2'h0, $past(card_cipher_active_o), 2'h0, $past(st)};
   endproperty
   a_rd_status: assert property (p_rd_status) else $error("bad status read");
endmodule
bind rbfcs_core rbfcs_monitor mon (.*);

// *** bench/rbfcs_card_model.sv ***
// card side model sending one framed receive bit stream
`timescale 1ns/1ps
module rbfcs_card_model (
   // frame set-up from the bench
   input  wire        ref_clk_i,
   input  wire        go_i,           // launch a frame
   input  wire        slow_i,         // idle cycle before each bit
   input  wire [15:0] pat_i,          // bit values, repeating
   input  wire [6:0]  len_i,          // data bits in the frame
   input  wire [6:0]  coll_i,         // collided bit index
   input  wire [6:0]  perr_i,         // bit index with bad parity
   // stream into the receiver
   output reg         sof_o = 1'b0,
   output reg         valid_o = 1'b0,
   output reg         bit_o = 1'b0,
   output reg         coll_o = 1'b0,
   output reg         perr_o = 1'b0,
   output reg         end_o = 1'b0,
   output reg         busy_o = 1'b0
);
   reg [6:0] k = 7'h00;              // bits sent so far
   reg       gap = 1'b0;             // idle cycle already spent
   // ****************************************
   // frame sequencer, off the falling edge
   // ****************************************
   always @(negedge ref_clk_i) begin
      sof_o   <= 1'b0;
      valid_o <= 1'b0;
      coll_o  <= 1'b0;
      perr_o  <= 1'b0;
      end_o   <= 1'b0;
      bit_o   <= ~bit_o;             // line toggles between bits, never stale
      if (go_i) begin
         busy_o <= 1'b1;
         sof_o  <= 1'b1;
         gap    <= 1'b0;
         k      <= 7'h00;
      end else if (busy_o && slow_i && !gap) begin
         gap <= 1'b1;                // slow card stalls one cycle
      end else if (busy_o && k == len_i) begin
         end_o  <= 1'b1;
         busy_o <= 1'b0;
      end else if (busy_o) begin
         gap     <= 1'b0;
         valid_o <= 1'b1;
         bit_o   <= pat_i[k[3:0]];
         coll_o  <= (k == coll_i);
         perr_o  <= (k == perr_i);
         k       <= k + 7'h01;
      end
   end
endmodule

// *** bench/rbfcs_core_tb.sv ***
// self-checking bench of the receive framing block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
   $display("wrong value %s exp %0h got %0h", n, e, g); end end
module rbfcs_core_tb;
   localparam [11:0] walk_codes = {3'h6, 3'h5, 3'h3, 3'h1}; // state after each event
   reg        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0, slow = 1'b0, crc = 1'b0;
   reg  [7:0] addr = 8'h00, wdata = 8'h00, v;
   reg  [5:0] ev = 6'h00;            // start, stop, auth, tx go, tx done, rx enable
   reg [15:0] pat = 16'h0000;
   reg  [6:0] len = 7'h00, cat = 7'h7F, per = 7'h7F;
   wire [7:0] rdata, rxb;
   wire [2:0] st;
   wire       sof, bv, bt, bc, pe, eof, busy, rxv, ie, cd, bo, ca;
   reg  [7:0] q[$];                  // bytes handed out this frame
   integer    num_errors = 0, checked = 0, n;
   initial forever #12.5 clk = ~clk;
   rbfcs_core dut (
      .ref_clk_i(clk), .reset_n_i(rst_n), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
      .reg_rd_i(rd), .reg_rdata_o(rdata), .cmd_start_i(ev[0]), .cmd_stop_i(ev[1]), .auth_done_i(ev[2]),
      .tx_go_i(ev[3]), .tx_done_i(ev[4]), .rx_enable_i(ev[5]), .rx_sof_i(sof), .rx_end_i(eof),
      .rx_bit_valid_i(bv), .rx_bit_i(bt), .rx_bit_coll_i(bc), .rx_parity_err_i(pe), .rx_crc_err_i(crc),
      .rx_byte_valid_o(rxv), .rx_byte_o(rxb), .transceiver_state_o(st), .card_cipher_active_o(ca),
      .integrity_error_flag_o(ie), .collision_detected_o(cd), .bit_oriented_o(bo));
   rbfcs_card_model card (
      .ref_clk_i(clk), .go_i(go), .slow_i(slow), .pat_i(pat), .len_i(len), .coll_i(cat), .perr_i(per),
      .sof_o(sof), .valid_o(bv), .bit_o(bt), .coll_o(bc), .perr_o(pe), .end_o(eof), .busy_o(busy));
   // collect every byte the receiver hands out
   always @(posedge clk) begin
      if (rxv) q.push_back(rxb);
   end
   task wr_reg(input [7:0] a, input [7:0] d);
      begin
         @(negedge clk);
         addr  <= a;
         wdata <= d;
         wr    <= 1'b1;
         @(negedge clk);
         wr    <= 1'b0;
      end
   endtask
   // read data shows at the taking edge and is sampled on the next falling edge
   task rd_reg(input [7:0] a, output [7:0] d);
      begin
         @(negedge clk);
         addr <= a;
         rd   <= 1'b1;
         @(negedge clk);
         rd   <= 1'b0;
         d     = rdata;
      end
   endtask
   task rd_chk(input [7:0] a, input [7:0] e);
      begin
         rd_reg(a, v);
         `CHK("read data", e, v)
      end
   endtask
   task pulse(input integer i);
      begin
         @(negedge clk);
         ev[i] <= 1'b1;
         @(negedge clk);
         ev    <= 6'h00;
      end
   endtask
   // walk the state machine to wait-for-data, then let the card send
   task frame(input [7:0] ctl, input [15:0] p, input [6:0] l, input [6:0] c, input [6:0] e, input s);
      integer j;
      begin
         wr_reg(8'h0C, ctl);
         q.delete();
         for (j = 0; j < 4; j++) begin
            pulse(j == 0 ? 0 : j + 2);
            `CHK("state", walk_codes[3*j +: 3], st)
         end
         `CHK("bit mode", |ctl[6:4], bo)
         `CHK("collision seen", 1'b0, cd)
         pat  <= p;
         len  <= l;
         cat  <= c;
         per  <= e;
         slow <= s;
         go   <= 1'b1;
         @(negedge clk);
         go   <= 1'b0;
         for (j = 0; j < 300 && (busy || go); j++) @(negedge clk);
         if (j == 300) begin
            num_errors++;
            end_sim;
         end
         repeat (2) @(negedge clk);
         `CHK("state", 3'h0, st)
      end
   endtask
   task end_sim;
      begin
         $display("mismatches %0d comparisons %0d", num_errors, checked);
         if (num_errors == 0 && checked > 0) $display("All checks passed");
         else $display("Checks failed");
         $finish;
      end
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (3) @(negedge clk);
      rst_n <= 1'b1;
      for (n = 11; n < 15; n++) rd_chk(n[7:0], 8'h00);
      wr_reg(8'h0B, 8'hFF);          // writing ones sets nothing
      wr_reg(8'h0D, 8'hFF);          // read-only register
      rd_chk(8'h0B, 8'h00);
      rd_chk(8'h0D, 8'h00);
      pulse(2);
      `CHK("cipher", 1'b1, ca)
      rd_chk(8'h0B, 8'h20);
      wr_reg(8'h0B, 8'hDF);
      rd_chk(8'h0B, 8'h00);
      `CHK("cipher", 1'b0, ca)
      pulse(0);
      rd_chk(8'h0B, 8'h01);
      pulse(1);
      // alignment 7, three bits
      frame(8'h70, 16'h0003, 7'h03, 7'h7F, 7'h7F, 1'b0);
      `CHK("byte 0", 8'h80, q[0])
      `CHK("byte 1", 8'h01, q[1])
      rd_chk(8'h0C, 8'h72);
      rd_chk(8'h0D, 8'h00);
      // alignment 4, collision on fourth bit, slow card
      frame(8'h48, 16'h003D, 7'h06, 7'h03, 7'h7F, 1'b1);
      `CHK("byte 0", 8'hD0, q[0])
      `CHK("byte 1", 8'h00, q[1])
      `CHK("integrity", 1'b1, ie)
      rd_chk(8'h0D, 8'h87);
      rd_chk(8'h0C, 8'h4A);
      // byte mode, values kept past a collision on the ninth bit
      frame(8'h80, 16'hA5C3, 7'h10, 7'h08, 7'h7F, 1'b0);
      `CHK("byte 0", 8'hC3, q[0])
      `CHK("byte 1", 8'hA5, q[1])
      `CHK("integrity", 1'b0, ie)
      rd_chk(8'h0D, 8'h88);
      rd_chk(8'h0C, 8'h80);
      // late checksum fault after the frame still raises the flag
      @(negedge clk);
      crc <= 1'b1;
      @(negedge clk);
      crc <= 1'b0;
      `CHK("integrity", 1'b1, ie)
      // parity error mid-frame
      frame(8'h00, 16'h005A, 7'h08, 7'h7F, 7'h03, 1'b0);
      `CHK("byte 0", 8'h5A, q[0])
      `CHK("integrity", 1'b1, ie)
      rd_chk(8'h0D, 8'h00);
      // last reportable bit, then one beyond
      frame(8'h80, 16'hFFFF, 7'h40, 7'h3F, 7'h7F, 1'b0);
      rd_chk(8'h0D, 8'hBF);
      frame(8'h80, 16'hFFFF, 7'h41, 7'h40, 7'h7F, 1'b0);
      `CHK("collision seen", 1'b1, cd)
      // host trusts the index only with the valid bit set
      rd_reg(8'h0D, v);
      `CHK("index valid", 1'b0, v[7])
      end_sim;
   end
endmodule
